// ==== rtl/slss_pkg.sv ====
// package: register map, reset values and flag layouts of the lane status block
package slss_pkg;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [13:0] IDX_LINK_PAGE = 14'h0300;
    localparam logic [13:0] IDX_THRESHOLD = 14'h0301;
    localparam logic [13:0] IDX_BAD_CTRL = 14'h046F;
    localparam logic [13:0] IDX_GROUP_SYNC = 14'h0470;
    localparam logic [13:0] IDX_IRQ_STATUS = 14'h0480;
    localparam logic [13:0] IDX_IRQ_MASK = 14'h0481;
    localparam int NUM_SYNC_LANES = 8;
    localparam int NUM_ERR_LANES = 3;
    localparam int CNT_W = 8;
    localparam int IRQ_W = NUM_SYNC_LANES + NUM_ERR_LANES;
    localparam logic [7:0] THRESHOLD_RST = 8'hFF;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [10:0] IRQ_RST = 11'h000;
    localparam int SYNC_STAGES = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // flags of the currently paged link
    typedef struct packed {
        logic [NUM_ERR_LANES-1:0] badCtrl;
        logic [NUM_SYNC_LANES-1:0] groupSync;
    } slss_flags_s;
endpackage

// ==== rtl/slss_bit_sync.sv ====
// two flip-flop synchroniser for a group of lane-domain signals
`timescale 1ns/100ps
`default_nettype none
module slss_bit_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rstSyncN,
    input wire logic [WIDTH-1:0] dataIn,
    output logic [WIDTH-1:0] dataOut
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            meta_q <= '0;
            dataOut <= '0;
        end else begin
            meta_q <= dataIn;
            dataOut <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/slss_status_top.sv ====
// lane sync and bad control character status registers with an AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - each of lanes 2..0 shows a bad control flag of 1 when its error count is at least the threshold.
// - the link page register chooses which link's lanes appear in the flags.
// - an eight-bit group sync register gives lane n's sync state in bit n for lanes 7..0.
// - a group sync flag reads 0 when the lane lost sync and 1 when it achieved it.
// - all lane flags are read-only and are zero after reset.
module slss_status_top #(
    parameter int NUM_LINKS = 2,
    parameter int LINK_W = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [NUM_LINKS*8-1:0] laneGroupSync,
    input wire logic [NUM_LINKS*24-1:0] laneErrCount,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    logic rstMeta_q, rstSyncN;
    logic [NUM_LINKS*8-1:0] syncSynced;
    logic [NUM_LINKS*24-1:0] cntSynced;
    logic [NUM_LINKS*24-1:0] cntPrev_q, cntHeld_q;
    logic [slss_pkg::NUM_ERR_LANES-1:0] badCtrlD;
    logic [LINK_W-1:0] linkPage_q;
    logic [7:0] threshold_q;
    slss_pkg::slss_flags_s flags_q, flags_d;
    logic [slss_pkg::IRQ_W-1:0] irqStat_q, irqStat_d, irqMask_q, irqEvt, irqClr;
    logic haveAw_q, haveW_q;
    logic [13:0] awIdx_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;

    // reset release through two flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta_q <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSyncN <= rstMeta_q;
        end
    end

    // lane inputs resynchronised
    // counts cross as plain words, so they are filtered for stability below
    slss_bit_sync #(.WIDTH(NUM_LINKS*8)) uSyncFlags (
        .clk(clk),
        .rstSyncN(rstSyncN),
        .dataIn(laneGroupSync),
        .dataOut(syncSynced)
    );
    slss_bit_sync #(.WIDTH(NUM_LINKS*24)) uSyncCounts (
        .clk(clk),
        .rstSyncN(rstSyncN),
        .dataIn(laneErrCount),
        .dataOut(cntSynced)
    );

    // a count word is taken only once two samples agree
    // costs two cycles of latency, but a word caught mid-change never lands
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            cntPrev_q <= '0;
            cntHeld_q <= '0;
        end else begin
            cntPrev_q <= cntSynced;
            if (cntSynced == cntPrev_q) cntHeld_q <= cntSynced;
        end
    end

    wire [7:0] syncSel = syncSynced[linkPage_q*8 +: 8];
    wire [23:0] cntSel = cntHeld_q[linkPage_q*24 +: 24];

    genvar g;
    generate
        for (g = 0; g < slss_pkg::NUM_ERR_LANES; g++) begin : gCmp
            assign badCtrlD[g] = cntSel[g*8 +: 8] >= threshold_q;
        end
    endgenerate
    assign flags_d = {badCtrlD, syncSel};

    // events: loss of sync and threshold reached
    assign irqEvt = {flags_d.badCtrl & ~flags_q.badCtrl, flags_q.groupSync & ~flags_d.groupSync};

    // bus decode
    wire awHs = s_axi_awvalid & s_axi_awready;
    wire wHs = s_axi_wvalid & s_axi_wready;
    wire arHs = s_axi_arvalid & s_axi_arready;
    wire doWrite = haveAw_q & haveW_q & ~s_axi_bvalid;
    wire [13:0] arIdx = s_axi_araddr[15:2];
    wire wrPage = doWrite & (awIdx_q == slss_pkg::IDX_LINK_PAGE) & wStrb_q[0];
    wire wrThr = doWrite & (awIdx_q == slss_pkg::IDX_THRESHOLD) & wStrb_q[0];
    wire wrStat = doWrite & (awIdx_q == slss_pkg::IDX_IRQ_STATUS);
    wire wrMask = doWrite & (awIdx_q == slss_pkg::IDX_IRQ_MASK);
    wire [10:0] wStrbBits = {{3{wStrb_q[1]}}, {8{wStrb_q[0]}}};
    wire wrMapped = (awIdx_q == slss_pkg::IDX_LINK_PAGE) | (awIdx_q == slss_pkg::IDX_THRESHOLD)
        | (awIdx_q == slss_pkg::IDX_BAD_CTRL) | (awIdx_q == slss_pkg::IDX_GROUP_SYNC)
        | wrStat | wrMask;
    assign irqClr = wrStat ? (wData_q[10:0] & wStrbBits) : '0;
    // set wins over a clear in the same cycle
    assign irqStat_d = (irqStat_q & ~irqClr) | irqEvt;

    // read mux; flag bits above the window read zero
    wire rdMapped = (arIdx == slss_pkg::IDX_LINK_PAGE) | (arIdx == slss_pkg::IDX_THRESHOLD)
        | (arIdx == slss_pkg::IDX_BAD_CTRL) | (arIdx == slss_pkg::IDX_GROUP_SYNC)
        | (arIdx == slss_pkg::IDX_IRQ_STATUS) | (arIdx == slss_pkg::IDX_IRQ_MASK);
    wire [31:0] rdVal =
        (arIdx == slss_pkg::IDX_LINK_PAGE) ? {{(32-LINK_W){1'b0}}, linkPage_q} :
        (arIdx == slss_pkg::IDX_THRESHOLD) ? {24'h000000, threshold_q} :
        (arIdx == slss_pkg::IDX_BAD_CTRL) ? {29'h00000000, flags_q.badCtrl} :
        (arIdx == slss_pkg::IDX_GROUP_SYNC) ? {24'h000000, flags_q.groupSync} :
        (arIdx == slss_pkg::IDX_IRQ_STATUS) ? {21'h000000, irqStat_q} :
        (arIdx == slss_pkg::IDX_IRQ_MASK) ? {21'h000000, irqMask_q} : 32'h00000000;

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            flags_q <= '0;
            irqStat_q <= slss_pkg::IRQ_RST;
            irq <= 1'b0;
        end else begin
            flags_q <= flags_d;
            irqStat_q <= irqStat_d;
            irq <= |(irqStat_q & irqMask_q);
        end
    end

    // software control registers
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            linkPage_q <= '0;
            threshold_q <= slss_pkg::THRESHOLD_RST;
            irqMask_q <= slss_pkg::IRQ_RST;
        end else begin
            if (wrPage) linkPage_q <= wData_q[LINK_W-1:0];
            if (wrThr) threshold_q <= wData_q[7:0];
            if (wrMask) irqMask_q <= (irqMask_q & ~wStrbBits) | (wData_q[10:0] & wStrbBits);
        end
    end
    // write channel: address and data in either order, then response
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            haveAw_q <= 1'b0;
            haveW_q <= 1'b0;
            awIdx_q <= '0;
            wData_q <= '0;
            wStrb_q <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= slss_pkg::RESP_OKAY;
        end else begin
            if (awHs) begin
                haveAw_q <= 1'b1;
                awIdx_q <= s_axi_awaddr[15:2];
                s_axi_awready <= 1'b0;
            end
            if (wHs) begin
                haveW_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                haveAw_q <= 1'b0;
                haveW_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrMapped ? slss_pkg::RESP_OKAY : slss_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read channel: one cycle to data
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= slss_pkg::RESP_OKAY;
        end else if (arHs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdVal;
            s_axi_rresp <= rdMapped ? slss_pkg::RESP_OKAY : slss_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // checks on the flags
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSyncN);

    property p_err_flag;
        flags_q.badCtrl[0] == ($past(cntSel[7:0]) >= $past(threshold_q));
    endproperty
    a_err_flag: assert property (p_err_flag) else $error("lane0 bad ctrl flag wrong");

    property p_err_flag2;
        flags_q.badCtrl[2] == ($past(cntSel[23:16]) >= $past(threshold_q));
    endproperty
    a_err_flag2: assert property (p_err_flag2) else $error("lane2 bad ctrl flag wrong");

    property p_page;
        ($past(linkPage_q, 3) == linkPage_q) |->
            flags_q.groupSync == $past(laneGroupSync[linkPage_q*8 +: 8], 3);
    endproperty
    a_page: assert property (p_page) else $error("paged sync flags do not follow input");

    sequence s_readSync;
        arHs && (arIdx == slss_pkg::IDX_GROUP_SYNC);
    endsequence
    property p_read_sync;
        s_readSync |=> s_axi_rvalid && (s_axi_rdata[7:0] == $past(flags_q.groupSync))
            && (s_axi_rdata[31:8] == 24'h000000);
    endproperty
    a_read_sync: assert property (p_read_sync) else $error("group sync readback wrong");

    property p_sync_lost;
        $fell(syncSel[0]) |=> !flags_q.groupSync[0] ##1 irqStat_q[0];
    endproperty
    a_sync_lost: assert property (p_sync_lost) else $error("sync loss not flagged");

    property p_reset_zero;
        @(posedge clk) disable iff (1'b0) !rstSyncN |-> (flags_q == '0);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("flags not zero in reset");

    property p_ro;
        (doWrite && (awIdx_q == slss_pkg::IDX_GROUP_SYNC)) |=>
            flags_q.groupSync == $past(syncSel);
    endproperty
    a_ro: assert property (p_ro) else $error("write disturbed read-only flags");

    property p_follow;
        $stable(linkPage_q)[*4] |-> flags_q.groupSync == $past(laneGroupSync[linkPage_q*8 +: 8], 3);
    endproperty
    a_follow: assert property (p_follow) else $error("flags lag lane input");
endmodule
`default_nettype wire

// ==== bench/slss_lane_tx_model.sv ====
// behavioural lane transmitter side feeding sync states and error counts
`timescale 1ns/100ps
`default_nettype none
module slss_lane_tx_model (
    input wire logic clk,
    input wire logic [15:0] syncSet,
    input wire logic [47:0] errSet,
    output logic [15:0] laneGroupSync,
    output logic [47:0] laneErrCount
);
    // registered on the bench clock, like the lane logic that drives the pins
    always @(posedge clk) begin
        laneGroupSync <= syncSet;
        laneErrCount <= errSet;
    end
endmodule
`default_nettype wire

// ==== bench/test_serial_lane_sync_status.sv ====
// self-checking bench for the lane status block over AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
module test_serial_lane_sync_status;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] syncSet = 16'h0000;
    logic [47:0] errSet = 48'h000000000000;
    logic [15:0] laneGroupSync;
    logic [47:0] laneErrCount;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata;
    logic [31:0] spare;
    logic [7:0] pats [4] = '{8'hA5, 8'h5A, 8'h01, 8'h80};
    logic [7:0] ths [4] = '{8'h0F, 8'h10, 8'h11, 8'h12};
    logic [2:0] exps [4] = '{3'h7, 3'h6, 3'h4, 3'h0};
    int fail_count = 0;
    int comparisons = 0;
    int cyc = 0;
    always #12.5 clk = ~clk;
    slss_lane_tx_model model_u (.clk(clk), .syncSet(syncSet), .errSet(errSet),
        .laneGroupSync(laneGroupSync), .laneErrCount(laneErrCount));
    slss_status_top dut_u (.clk(clk), .rstn(rstn), .laneGroupSync(laneGroupSync),
        .laneErrCount(laneErrCount), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
    task automatic give_verdict();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic axi_write(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
        logic done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            awvalid <= awvalid & ~awready;
            wvalid <= wvalid & ~wready;
            done = bvalid & bready;
        end
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            arvalid <= arvalid & ~arready;
            done = rvalid & rready;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check({nm, " data"}, d, exp);
        check({nm, " resp"}, {30'h0, r}, {30'h0, slss_pkg::RESP_OKAY});
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        axi_write(a, d, rs);
        check("write resp", {30'h0, rs}, {30'h0, slss_pkg::RESP_OKAY});
    endtask
    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        rdchk(16'h11C0, 32'h0, "groupSync reset");
        rdchk(16'h11BC, 32'h0, "badCtrl reset");
        // every lane seen in its own bit, both levels
        for (int i = 0; i < 4; i++) begin
            syncSet[7:0] <= pats[i];
            repeat (6) @(posedge clk);
            rdchk(16'h11C0, {24'h0, pats[i]}, "groupSync lanes");
        end
        wr(16'h11C0, 32'h000000FF);
        rdchk(16'h11C0, 32'h80, "groupSync after write");
        // counts straddle the threshold by one either way
        errSet[23:0] <= {8'h11, 8'h10, 8'h0F};
        for (int i = 0; i < 4; i++) begin
            wr(16'h0C04, {24'h0, ths[i]});
            repeat (6) @(posedge clk);
            rdchk(16'h11BC, {29'h0, exps[i]}, "badCtrl threshold");
        end
        syncSet[15:8] <= 8'h3C;
        errSet[47:24] <= {8'h00, 8'hFF, 8'h00};
        wr(16'h0C00, 32'h1);
        repeat (6) @(posedge clk);
        rdchk(16'h11C0, 32'h3C, "groupSync link1");
        rdchk(16'h11BC, 32'h2, "badCtrl link1");
        wr(16'h0C00, 32'h0);
        repeat (6) @(posedge clk);
        rdchk(16'h11C0, 32'h80, "groupSync link0");
        axi_read(16'h0100, spare, rs);
        check("unmapped data", spare, 32'h0);
        check("unmapped resp", {30'h0, rs}, {30'h0, slss_pkg::RESP_SLVERR});
        // sync loss raises the interrupt only while unmasked
        wr(16'h1204, 32'h7FF);
        wr(16'h1200, 32'h7FF);
        repeat (3) @(posedge clk);
        check("irq idle", {31'h0, irq}, 32'h0);
        syncSet[7] <= 1'b0;
        repeat (7) @(posedge clk);
        check("irq raised", {31'h0, irq}, 32'h1);
        rdchk(16'h1200, 32'h80, "irq status");
        wr(16'h1204, 32'h0);
        repeat (3) @(posedge clk);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(16'h1200, 32'h80);
        rdchk(16'h1200, 32'h0, "irq status cleared");
        give_verdict();
    end
endmodule
`default_nettype wire
